/* File: design/vocoder_info_pkg.sv */
package vocoder_info_pkg;
  // register addresses on the serial control bus
  localparam logic [7:0] ADDR_VOCODER_CONFIG_REG      = 8'h07;
  localparam logic [7:0] ADDR_SVC_REQ   = 8'h0E;
  localparam logic [7:0] ADDR_VOCODER_CONTROL_REG     = 8'h11;
  localparam logic [7:0] ADDR_IRQ_MASK  = 8'h1F;
  localparam logic [7:0] ADDR_PEAK      = 8'h31;
  localparam logic [7:0] ADDR_DEC_INFO  = 8'h37;
  localparam logic [7:0] ADDR_ENC_INFO  = 8'h38;
  localparam logic [7:0] ADDR_STATUS    = 8'h40;
  localparam logic [7:0] ADDR_READ_BASE = 8'h30;
  // service request code that turns peak reporting on
  localparam logic [7:0] SVC_PEAK_ON    = 8'h09;
  // reset values
  localparam logic [15:0] IRQ_MASK_RST  = 16'h8000;
  localparam logic [15:0] WORD_ZERO     = 16'h0000;
  // status flag positions
  localparam int ST_PACKET = 0;
  localparam int ST_ENC    = 1;
  localparam int ST_DEC    = 2;
  localparam int ST_PEAK   = 6;
  localparam int ST_WANTED = 8;
  localparam int ST_SVC    = 14;
  localparam int ST_READY  = 15;
  // configuration and control bit positions
  localparam int CFG_DTMF_FMT  = 7;
  localparam int CTL_DEC_DTMF  = 8;
  localparam int CTL_DEC_TONE  = 9;
  localparam int CTL_ENC_DTMF  = 11;
  localparam int CTL_ENC_TONE  = 12;
  // frame type codes, held in bits 15:14
  localparam logic [1:0] TYPE_VOICE = 2'h0;
  localparam logic [1:0] TYPE_DTMF  = 2'h1;
  localparam logic [1:0] TYPE_TONE  = 2'h2;
  // serial word lengths
  localparam logic [4:0] LEN_ADDR = 5'h08;
  localparam logic [4:0] LEN_BYTE = 5'h08;
  localparam logic [4:0] LEN_WORD = 5'h10;

  typedef enum logic [1:0] {
    CB_IDLE = 2'b00,
    CB_ADDR = 2'b01,
    CB_WR   = 2'b10,
    CB_RD   = 2'b11
  } cbus_state_t;

  // only the service request register takes a single byte
  function automatic logic [4:0] write_len(input logic [7:0] a);
    write_len = (a == ADDR_SVC_REQ) ? LEN_BYTE : LEN_WORD;
  endfunction : write_len

  // format bit set: key zero travels as code ten and back
  function automatic logic [3:0] dtmf_code(input logic [3:0] key,
                                           input logic       fmt);
    dtmf_code = key;
    if (fmt && key == 4'h0) begin
      dtmf_code = 4'hA;
    end else if (fmt && key == 4'hA) begin
      dtmf_code = 4'h0;
    end
  endfunction : dtmf_code
endpackage : vocoder_info_pkg

/* File: design/frame_info_format.sv */
`timescale 1ns/1ps
module frame_info_format
  import vocoder_info_pkg::*;
(
  // frame description from the codec core
  input  wire logic [1:0]  frame_type,
  input  wire logic [3:0]  dtmf_key,
  input  wire logic [11:0] tone_freq,
  input  wire logic        from_send,
  input  wire logic [3:0]  send_left,
  // host settings
  input  wire logic        dtmf_en,
  input  wire logic        tone_en,
  input  wire logic        dtmf_fmt,
  // packed register word
  output logic      [15:0] info_word
);
  // pack type, data and count; disabled kinds fall back to voice
  always_comb begin
    info_word = WORD_ZERO;
    if (frame_type == TYPE_DTMF && dtmf_en) begin
      info_word[15:14] = TYPE_DTMF;
      info_word[3:0]   = dtmf_code(dtmf_key, dtmf_fmt);
      if (from_send) begin
        info_word[7:4] = send_left;
      end
    end else if (frame_type == TYPE_TONE && tone_en) begin
      info_word[15:14] = TYPE_TONE;
      info_word[11:0]  = tone_freq;
    end
  end
endmodule : frame_info_format

/* File: design/cbus_serial_slave.sv */
`timescale 1ns/1ps
module cbus_serial_slave
  import vocoder_info_pkg::*;
(
  // clock, reset, enable
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        clk_en,
  // serial pins
  input  wire logic        cbus_csn,
  input  wire logic        cbus_sclk,
  input  wire logic        cbus_cdata,
  output logic             cbus_rdata,
  output logic             cbus_rdata_oe,
  // register side
  output logic      [7:0]  reg_addr,
  output logic      [15:0] wr_data,
  output logic             wr_stb,
  output logic             rd_stb,
  input  wire logic [15:0] rd_data
);
  cbus_state_t state_r, state_nxt;
  logic [15:0] shift_r, shift_nxt;
  logic [4:0]  cnt_r, cnt_nxt;
  logic [7:0]  addr_r, addr_nxt;
  logic        sclk_r, load_r, load_nxt, wr_r, wr_nxt;
  logic        rdat_r, rdat_nxt, oe_r, oe_nxt;
  logic        rise, fall;

  // pins are synchronous to ref_clk, so edges come from one stage
  assign rise = cbus_sclk & ~sclk_r;
  assign fall = ~cbus_sclk & sclk_r;

  // bit sequencing: address byte, then write data or read data
  always_comb begin
    state_nxt = state_r;
    shift_nxt = shift_r;
    cnt_nxt   = cnt_r;
    addr_nxt  = addr_r;
    load_nxt  = 1'b0;
    wr_nxt    = 1'b0;
    rdat_nxt  = rdat_r;
    oe_nxt    = oe_r;
    if (cbus_csn) begin
      // deselect aborts any half-shifted word
      state_nxt = CB_IDLE;
      oe_nxt    = 1'b0;
    end else begin
      unique case (state_r)
        CB_IDLE: begin
          state_nxt = CB_ADDR;
          cnt_nxt   = 5'h00;
        end
        CB_ADDR: if (rise) begin
          addr_nxt = {addr_r[6:0], cbus_cdata};
          cnt_nxt  = cnt_r + 5'h01;
          if (cnt_nxt == LEN_ADDR) begin
            cnt_nxt = 5'h00;
            if (addr_nxt >= ADDR_READ_BASE) begin
              state_nxt = CB_RD;
              load_nxt  = 1'b1;
            end else begin
              state_nxt = CB_WR;
            end
          end
        end
        CB_WR: if (rise) begin
          shift_nxt = {shift_r[14:0], cbus_cdata};
          cnt_nxt   = cnt_r + 5'h01;
          if (cnt_nxt == write_len(addr_r)) begin
            wr_nxt    = 1'b1;
            state_nxt = CB_IDLE;
          end
        end
        CB_RD: begin
          if (load_r) begin
            // word captured the cycle after the address completes
            shift_nxt = {rd_data[14:0], 1'b0};
            rdat_nxt  = rd_data[15];
            oe_nxt    = 1'b1;
          end else if (fall) begin
            rdat_nxt  = shift_r[15];
            shift_nxt = {shift_r[14:0], 1'b0};
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_r <= CB_IDLE;
      shift_r <= WORD_ZERO;
      cnt_r   <= 5'h00;
      addr_r  <= 8'h00;
      sclk_r  <= 1'b0;
      load_r  <= 1'b0;
      wr_r    <= 1'b0;
      rdat_r  <= 1'b0;
      oe_r    <= 1'b0;
    end else if (clk_en) begin
      state_r <= state_nxt;
      shift_r <= shift_nxt;
      cnt_r   <= cnt_nxt;
      addr_r  <= addr_nxt;
      sclk_r  <= cbus_sclk;
      load_r  <= load_nxt;
      wr_r    <= wr_nxt;
      rdat_r  <= rdat_nxt;
      oe_r    <= oe_nxt;
    end
  end

  assign reg_addr      = addr_r;
  assign wr_data       = shift_r;
  assign wr_stb        = wr_r;
  assign rd_stb        = load_r;
  assign cbus_rdata    = rdat_r;
  assign cbus_rdata_oe = oe_r;
endmodule : cbus_serial_slave

/* File: design/vocoder_irq_mask_frame_info_regs.sv */
`timescale 1ns/1ps
module vocoder_irq_mask_frame_info_regs
  import vocoder_info_pkg::*;
(
  // clock, reset, enable
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        clk_en,
  // serial control bus pins
  input  wire logic        cbus_csn,
  input  wire logic        cbus_sclk,
  input  wire logic        cbus_cdata,
  output logic             cbus_rdata,
  output logic             cbus_rdata_oe,
  // open-drain interrupt pin
  output logic             interrupt_request_n,
  output logic             interrupt_request_oe,
  // events from the rest of the device
  input  wire logic        ready_evt,
  input  wire logic        service_evt,
  input  wire logic        data_wanted_evt,
  input  wire logic        packet_avail_evt,
  // peak level of each encoded frame
  input  wire logic        peak_done,
  input  wire logic [14:0] peak_value,
  // encoded frame description
  input  wire logic        enc_done,
  input  wire logic [1:0]  enc_type,
  input  wire logic [3:0]  enc_key,
  input  wire logic [11:0] enc_freq,
  input  wire logic        enc_from_send,
  input  wire logic [3:0]  enc_send_left,
  // decoded frame description
  input  wire logic        dec_done,
  input  wire logic [1:0]  dec_type,
  input  wire logic [3:0]  dec_key,
  input  wire logic [11:0] dec_freq,
  // settings seen by the rest of the device
  output logic      [15:0] vocoder_config_reg,
  output logic      [15:0] vocoder_control_reg,
  output logic      [7:0]  service_request_reg,
  output logic             service_req_stb
);
  logic [7:0]  reg_addr;
  logic [15:0] wr_data;
  logic        wr_stb;
  logic        rd_stb;
  logic [15:0] rd_data;
  logic [15:0] enc_word;
  logic [15:0] dec_word;

  logic [15:0] mask_r, mask_nxt;
  logic [15:0] cfg_r, cfg_nxt;
  logic [15:0] ctl_r, ctl_nxt;
  logic [7:0]  svc_r, svc_nxt;
  logic        svc_stb_r, svc_stb_nxt;
  logic        peak_on_r, peak_on_nxt;
  logic [15:0] peak_r, peak_nxt;
  logic [15:0] enc_info_r, enc_info_nxt;
  logic [15:0] dec_info_r, dec_info_nxt;
  logic [15:0] status_r, status_nxt;
  logic [15:0] set_vec;
  logic        irq_r, irq_nxt;

  // serial bus front end
  cbus_serial_slave u_slave (
    .ref_clk       (ref_clk),
    .rst           (rst),
    .clk_en        (clk_en),
    .cbus_csn      (cbus_csn),
    .cbus_sclk     (cbus_sclk),
    .cbus_cdata    (cbus_cdata),
    .cbus_rdata    (cbus_rdata),
    .cbus_rdata_oe (cbus_rdata_oe),
    .reg_addr      (reg_addr),
    .wr_data       (wr_data),
    .wr_stb        (wr_stb),
    .rd_stb        (rd_stb),
    .rd_data       (rd_data)
  );

  // encoder side word: detection uses encoder enables
  frame_info_format u_enc_fmt (
    .frame_type (enc_type),
    .dtmf_key   (enc_key),
    .tone_freq  (enc_freq),
    .from_send  (enc_from_send),
    .send_left  (enc_send_left),
    .dtmf_en    (ctl_r[CTL_ENC_DTMF]),
    .tone_en    (ctl_r[CTL_ENC_TONE]),
    .dtmf_fmt   (cfg_r[CFG_DTMF_FMT]),
    .info_word  (enc_word)
  );

  // decoder side never carries a send count
  frame_info_format u_dec_fmt (
    .frame_type (dec_type),
    .dtmf_key   (dec_key),
    .tone_freq  (dec_freq),
    .from_send  (1'b0),
    .send_left  (4'h0),
    .dtmf_en    (ctl_r[CTL_DEC_DTMF]),
    .tone_en    (ctl_r[CTL_DEC_TONE]),
    .dtmf_fmt   (cfg_r[CFG_DTMF_FMT]),
    .info_word  (dec_word)
  );

  // read mux; the mask is write-only and reads as zero
  always_comb begin
    unique case (reg_addr)
      ADDR_PEAK:     rd_data = peak_r;
      ADDR_DEC_INFO: rd_data = dec_info_r;
      ADDR_ENC_INFO: rd_data = enc_info_r;
      ADDR_STATUS:   rd_data = status_r;
      default:       rd_data = WORD_ZERO;
    endcase
  end

  // host-written settings
  always_comb begin
    mask_nxt    = mask_r;
    cfg_nxt     = cfg_r;
    ctl_nxt     = ctl_r;
    svc_nxt     = svc_r;
    svc_stb_nxt = 1'b0;
    peak_on_nxt = peak_on_r;
    if (wr_stb) begin
      unique case (reg_addr)
        ADDR_IRQ_MASK: mask_nxt = wr_data;
        ADDR_VOCODER_CONFIG_REG:     cfg_nxt  = wr_data;
        ADDR_VOCODER_CONTROL_REG:    ctl_nxt  = wr_data;
        ADDR_SVC_REQ: begin
          svc_nxt     = wr_data[7:0];
          svc_stb_nxt = 1'b1;
          if (wr_data[7:0] == SVC_PEAK_ON) begin
            peak_on_nxt = 1'b1;
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mask_r    <= IRQ_MASK_RST;
      cfg_r     <= WORD_ZERO;
      ctl_r     <= WORD_ZERO;
      svc_r     <= 8'h00;
      svc_stb_r <= 1'b0;
      peak_on_r <= 1'b0;
    end else if (clk_en) begin
      mask_r    <= mask_nxt;
      cfg_r     <= cfg_nxt;
      ctl_r     <= ctl_nxt;
      svc_r     <= svc_nxt;
      svc_stb_r <= svc_stb_nxt;
      peak_on_r <= peak_on_nxt;
    end
  end

  // frame information registers, each held until its next event
  always_comb begin
    peak_nxt     = peak_r;
    enc_info_nxt = enc_info_r;
    dec_info_nxt = dec_info_r;
    if (peak_done && peak_on_r) begin
      peak_nxt = {1'b0, peak_value};
    end
    if (enc_done) begin
      enc_info_nxt = enc_word;
    end
    if (dec_done) begin
      dec_info_nxt = dec_word;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      peak_r     <= WORD_ZERO;
      enc_info_r <= WORD_ZERO;
      dec_info_r <= WORD_ZERO;
    end else if (clk_en) begin
      peak_r     <= peak_nxt;
      enc_info_r <= enc_info_nxt;
      dec_info_r <= dec_info_nxt;
    end
  end

  // status flags; a read clears them but a same-cycle event survives
  always_comb begin
    set_vec = WORD_ZERO;
    set_vec[ST_READY]  = ready_evt;
    set_vec[ST_SVC]    = service_evt;
    set_vec[ST_WANTED] = data_wanted_evt;
    set_vec[ST_PEAK]   = peak_done & peak_on_r;
    set_vec[ST_DEC]    = dec_done;
    set_vec[ST_ENC]    = enc_done;
    set_vec[ST_PACKET] = packet_avail_evt;
    status_nxt = status_r;
    if (rd_stb && reg_addr == ADDR_STATUS) begin
      status_nxt = WORD_ZERO;
    end
    status_nxt = status_nxt | set_vec;
    irq_nxt = |(status_nxt & mask_nxt);
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      status_r <= WORD_ZERO;
      irq_r    <= 1'b0;
    end else if (clk_en) begin
      status_r <= status_nxt;
      irq_r    <= irq_nxt;
    end
  end

  // open drain: the pin is only ever pulled low
  assign interrupt_request_n  = 1'b0;
  assign interrupt_request_oe = irq_r;
  assign vocoder_config_reg   = cfg_r;
  assign vocoder_control_reg  = ctl_r;
  assign service_request_reg  = svc_r;
  assign service_req_stb      = svc_stb_r;
endmodule : vocoder_irq_mask_frame_info_regs

/* File: verification/irq_info_monitor.sv */
`timescale 1ns/1ps
module irq_info_monitor
  import vocoder_info_pkg::*;
(
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        clk_en,
  // serial pins
  input wire logic        cbus_csn,
  input wire logic        cbus_sclk,
  input wire logic        cbus_rdata,
  input wire logic        cbus_rdata_oe,
  // interrupt pin
  input wire logic        interrupt_request_n,
  input wire logic        interrupt_request_oe,
  // events
  input wire logic        ready_evt,
  input wire logic        service_evt,
  input wire logic        data_wanted_evt,
  input wire logic        packet_avail_evt,
  input wire logic        peak_done,
  input wire logic        enc_done,
  input wire logic        dec_done,
  // settings
  input wire logic [15:0] vocoder_config_reg,
  input wire logic [15:0] vocoder_control_reg,
  input wire logic        service_req_stb
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic any_evt;
  logic fresh_r;
  logic fresh_nxt;
  // any event port that may set a status flag
  assign any_evt = clk_en & (ready_evt | service_evt | data_wanted_evt
                   | packet_avail_evt | peak_done | enc_done | dec_done);
  // mask is known to hold its reset value until the first select
  always_comb begin
    fresh_nxt = fresh_r & cbus_csn;
    if (rst) begin
      fresh_nxt = 1'b1;
    end
  end
  always_ff @(posedge ref_clk) begin
    fresh_r <= fresh_nxt;
  end
  // six idle cycles: any late register update has landed by then
  sequence s_quiet;
    cbus_csn [*6];
  endsequence
  sequence s_ready;
    ready_evt && clk_en && fresh_r;
  endsequence
  property p_rst_vals;
    $fell(rst) |-> !interrupt_request_oe && !cbus_rdata_oe
      && vocoder_config_reg == WORD_ZERO && vocoder_control_reg == WORD_ZERO;
  endproperty
  property p_ready_irq;
    s_ready |=> interrupt_request_oe;
  endproperty
  property p_pin_low;
    interrupt_request_n == 1'b0;
  endproperty
  property p_irq_cause;
    s_quiet ##0 $rose(interrupt_request_oe) |-> $past(any_evt);
  endproperty
  property p_irq_hold;
    s_quiet ##0 interrupt_request_oe |=> interrupt_request_oe;
  endproperty
  property p_rdata_rel;
    cbus_csn [*2] |-> !cbus_rdata_oe;
  endproperty
  property p_rdata_hold;
    cbus_rdata_oe && $past(cbus_rdata_oe) && cbus_sclk && $past(cbus_sclk)
      |-> $stable(cbus_rdata);
  endproperty
  property p_svc_pulse;
    service_req_stb |=> !service_req_stb;
  endproperty
  property p_cfg_quiet;
    s_quiet |=> $stable(vocoder_config_reg) && $stable(vocoder_control_reg);
  endproperty
  a_rst_vals: assert property (p_rst_vals)
    else $error("reset values wrong");
  a_ready_irq: assert property (p_ready_irq)
    else $error("ready event raised no interrupt");
  a_pin_low: assert property (p_pin_low)
    else $error("interrupt pin level not low");
  a_irq_cause: assert property (p_irq_cause)
    else $error("interrupt rose without an event");
  a_irq_hold: assert property (p_irq_hold)
    else $error("interrupt dropped without a status read");
  a_rdata_rel: assert property (p_rdata_rel)
    else $error("read data still driven while deselected");
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data moved while serial clock high");
  a_svc_pulse: assert property (p_svc_pulse)
    else $error("service strobe longer than one cycle");
  a_cfg_quiet: assert property (p_cfg_quiet)
    else $error("settings changed with the bus idle");
endmodule : irq_info_monitor
bind vocoder_irq_mask_frame_info_regs irq_info_monitor mon_u (.*);

/* File: verification/cbus_host.sv */
`timescale 1ns/1ps
module cbus_host
  import vocoder_info_pkg::*;
(
  // clock
  input wire logic ref_clk,
  // serial pins
  input wire logic cbus_rdata,
  input wire logic cbus_rdata_oe,
  output logic     cbus_csn,
  output logic     cbus_sclk,
  output logic     cbus_cdata
);
  initial begin
    cbus_csn = 1'b1;
    cbus_sclk = 1'b0;
    cbus_cdata = 1'b0;
  end
  // step just past the edge so no change races the sampling
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick
  // one bit: data set with sclk low, each phase three cycles
  task automatic pulse(input logic d);
    cbus_cdata = d;
    cbus_sclk = 1'b0;
    tick(3);
    cbus_sclk = 1'b1;
    tick(3);
  endtask : pulse
  // one register per select; a read bit is taken before each fall
  task automatic xfer(input logic [7:0] a, input logic [15:0] wd,
                      output logic [15:0] rd);
    int nw;
    nw = (a == ADDR_SVC_REQ) ? 8 : 16;
    rd = 16'h0000;
    cbus_csn = 1'b0;
    tick(1);
    for (int i = 7; i >= 0; i--) pulse(a[i]);
    if (a >= ADDR_READ_BASE) begin
      for (int i = 15; i >= 0; i--) begin
        rd[i] = cbus_rdata_oe ? cbus_rdata : 1'bx;
        if (i > 0) pulse(~cbus_cdata);
      end
    end else begin
      for (int i = nw - 1; i >= 0; i--) pulse(wd[i]);
    end
    // released data line is not left showing its last bit
    cbus_csn = 1'b1;
    cbus_sclk = 1'b0;
    cbus_cdata = ~cbus_cdata;
    tick(2);
  endtask : xfer
endmodule : cbus_host

/* File: verification/testbench.sv */
`timescale 1ns/1ps
module testbench;
  import vocoder_info_pkg::*;
  logic        ref_clk, rst, clk_en;
  logic        cbus_csn, cbus_sclk, cbus_cdata;
  logic        cbus_rdata, cbus_rdata_oe;
  logic        interrupt_request_n, interrupt_request_oe;
  logic        ready_evt, service_evt, data_wanted_evt, packet_avail_evt;
  logic        peak_done, enc_done, dec_done, enc_from_send;
  logic [14:0] peak_value;
  logic [1:0]  enc_type, dec_type;
  logic [3:0]  enc_key, enc_send_left, dec_key;
  logic [11:0] enc_freq, dec_freq;
  logic [15:0] vocoder_config_reg, vocoder_control_reg;
  logic [7:0]  service_request_reg;
  logic        service_req_stb;
  logic [6:0]  ev_v;
  int          n_mismatch = 0;
  int          samples_checked = 0;
  int          seed = 32'h708D0CED;
  int          status_m = 0, mask_m = 16'h8000, cfg_m = 0, ctl_m = 0;
  int          peak_m = 0, enc_m = 0, dec_m = 0, peak_on_m = 0;
  int          enc_k = 16'hC000, dec_k = 16'hC000;
  int          pos[7] = '{ST_READY, ST_SVC, ST_WANTED, ST_PACKET,
                          ST_PEAK, ST_ENC, ST_DEC};
  // one-hot event vector drives all event ports
  assign {dec_done, enc_done, peak_done, packet_avail_evt,
          data_wanted_evt, service_evt, ready_evt} = ev_v;
  vocoder_irq_mask_frame_info_regs dut_u (.*);
  cbus_host host_u (.*);
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  task automatic test_done;
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done
  // bits outside the mask carry no meaning and are not compared
  // reserved bits ignored
  task automatic chk(input logic [15:0] g, input int e, input int m);
    samples_checked++;
    if ((g & m[15:0]) !== (e[15:0] & m[15:0])) begin
      n_mismatch++;
      $display("MISMATCH %0t got %h want %h", $time, g, e[15:0]);
    end
  endtask : chk
  // expected frame word, worked out from type, enables and format
  function automatic int fword(input logic [1:0] t, input logic [3:0] k,
                               input logic [11:0] f, input logic s,
                               input logic [3:0] n, input logic de,
                               input logic te, output int m);
    int c;
    c = k;
    if (cfg_m[CFG_DTMF_FMT] && k == 4'h0) c = 10;
    if (cfg_m[CFG_DTMF_FMT] && k == 4'hA) c = 0;
    fword = 0;
    m = 16'hC000;
    if (t == TYPE_DTMF && de) begin
      fword = 16'h4000 + (s ? n * 16 : 0) + c;
      m = s ? 16'hC0FF : 16'hC00F;
    end else if (t == TYPE_TONE && te) begin
      fword = 16'h8000 + f;
      m = 16'hCFFF;
    end
  endfunction : fword
  task automatic rd_chk(input logic [7:0] a, input int e, input int m);
    logic [15:0] d;
    host_u.xfer(a, 16'h0000, d);
    chk(d, e, m);
    if (a == ADDR_STATUS) status_m = 0;
  endtask : rd_chk
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [15:0] x;
    host_u.xfer(a, d, x);
    if (a == ADDR_IRQ_MASK) mask_m = d;
    if (a == ADDR_VOCODER_CONFIG_REG) cfg_m = d;
    if (a == ADDR_VOCODER_CONTROL_REG) ctl_m = d;
    if (a == ADDR_SVC_REQ && d[7:0] == SVC_PEAK_ON) peak_on_m = 1;
    if (a == ADDR_SVC_REQ) chk({8'h00, service_request_reg}, d, 16'h00FF);
    chk(vocoder_config_reg, cfg_m, 16'hFFFF);
    chk(vocoder_control_reg, ctl_m, 16'hFFFF);
  endtask : wr
  task automatic irq_chk;
    chk({15'h0000, interrupt_request_oe}, (status_m & mask_m) != 0, 1);
  endtask : irq_chk
  // one event with fresh random frame data, then the model follows
  task automatic evt(input int k);
    {enc_type, enc_key, enc_freq, enc_from_send, enc_send_left}
      = 23'($random(seed));
    {dec_type, dec_key, dec_freq} = 18'($random(seed));
    peak_value = 15'($random(seed));
    ev_v = 7'(1 << k);
    @(posedge ref_clk);
    #1 ev_v = 7'h00;
    if (k != 4 || peak_on_m != 0) status_m |= 1 << pos[k];
    if (k == 4 && peak_on_m != 0) peak_m = peak_value;
    if (k == 5) enc_m = fword(enc_type, enc_key, enc_freq, enc_from_send,
      enc_send_left, ctl_m[CTL_ENC_DTMF], ctl_m[CTL_ENC_TONE], enc_k);
    if (k == 6) dec_m = fword(dec_type, dec_key, dec_freq, 1'b0, 4'h0,
      ctl_m[CTL_DEC_DTMF], ctl_m[CTL_DEC_TONE], dec_k);
    @(posedge ref_clk);
    #1;
  endtask : evt
  // main sequence
  initial begin
    ev_v = 7'h00;
    {enc_type, enc_key, enc_freq, enc_from_send, enc_send_left} = 23'h0;
    {dec_type, dec_key, dec_freq} = 18'h0;
    peak_value = 15'h0000;
    clk_en = 1'b1;
    rst = 1'b1;
    repeat (4) @(posedge ref_clk);
    #1 rst = 1'b0;
    irq_chk;
    evt(0);
    irq_chk;
    rd_chk(ADDR_STATUS, status_m, 16'hC147);
    irq_chk;
    // frozen clock enable: this ready event must be lost
    clk_en = 1'b0;
    ev_v = 7'h01;
    @(posedge ref_clk);
    #1 ev_v = 7'h00;
    clk_en = 1'b1;
    irq_chk;
    evt(4);
    rd_chk(ADDR_STATUS, status_m, 16'hC147);
    rd_chk(ADDR_PEAK, 0, 16'hFFFF);
    rd_chk(8'h3F, 0, 16'hFFFF);
    for (int i = 0; i < 16; i++) begin
      wr(ADDR_IRQ_MASK, 16'($random(seed)));
      wr(ADDR_VOCODER_CONFIG_REG, 16'($random(seed)));
      wr(ADDR_VOCODER_CONTROL_REG, 16'($random(seed)));
      if (i == 3) wr(ADDR_SVC_REQ, {8'h00, SVC_PEAK_ON});
      repeat (3) evt({$random(seed)} % 7);
      irq_chk;
      rd_chk(ADDR_DEC_INFO, dec_m, dec_k);
      rd_chk(ADDR_ENC_INFO, enc_m, enc_k);
      rd_chk(ADDR_PEAK, peak_m, 16'hFFFF);
      rd_chk(ADDR_STATUS, status_m, 16'hC147);
      irq_chk;
    end
    test_done;
  end
  // watchdog: the sequence needs about 17000 cycles
  initial begin
    repeat (80000) @(posedge ref_clk);
    n_mismatch++;
    test_done;
  end
endmodule : testbench
